// ---- src/rglm_pkg.sv ----
/*
 * Constants for the receiver gain and local oscillator monitor bank:
 * register offsets, field values, reset values, management frame
 * layout and averaging widths.
 * Assumes the 16-bit management address space of the module.
 */
package rglm_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [15:0] A_FEAT    = 16'hBB8C;
  localparam logic [15:0] A_RSVD    = 16'hBBC6;
  localparam logic [15:0] A_GAIN    = 16'hBBC8;
  localparam logic [15:0] A_TARGET  = 16'hBBCC;
  localparam logic [15:0] A_LO_MON  = 16'hBBD0;
  localparam logic [15:0] A_LO_SET  = 16'hBBD1;
  localparam logic [15:0] A_LO_MIN  = 16'hBBD2;
  localparam logic [15:0] A_LO_MAX  = 16'hBBD3;
  localparam logic [15:0] A_DET_CUR = 16'hBBD4;
  localparam logic [15:0] A_DET_AVG = 16'hBBD8;
  localparam logic [15:0] A_DET_MIN = 16'hBBDC;
  localparam logic [15:0] A_DET_MAX = 16'hBBE0;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int          NCH       = 4;
  localparam logic [1:0]  GM_MANUAL = 2'h0;
  localparam logic [1:0]  GM_AUTO   = 2'h1;
  localparam logic [13:0] FEAT_PAD  = 14'h0000;
  localparam logic [15:0] RST_VAL   = 16'h0000;
  localparam logic [15:0] RMIN_RST  = 16'hFFFF;

  // ****************************************
  // Averaging
  // ****************************************
  localparam logic [23:0] CNT_MAX   = 24'hFFFFFF;
  localparam logic [23:0] SUM_PAD   = 24'h000000;
  localparam logic [5:0]  DIV_LAST  = 6'h27;

  // ****************************************
  // Management frame
  // ****************************************
  localparam logic [5:0]  PRE_LEN   = 6'h20;
  localparam logic [4:0]  BIT_HDR   = 5'h0D;
  localparam logic [4:0]  BIT_TA    = 5'h0E;
  localparam logic [4:0]  BIT_TA2   = 5'h0F;
  localparam logic [4:0]  BIT_LAST  = 5'h1F;
  localparam logic [1:0]  ST_C45    = 2'h0;
  localparam logic [1:0]  OP_ADDR   = 2'h0;
  localparam logic [1:0]  OP_WR     = 2'h1;
  localparam logic [1:0]  OP_RDINC  = 2'h2;
  localparam logic [1:0]  OP_RD     = 2'h3;
  localparam logic [4:0]  PORT_ADDR = 5'h00;
  localparam logic [4:0]  DEV_ADDR  = 5'h01;

  typedef enum logic {MS_HUNT, MS_FRAME} rglm_mdio_state_t;

endpackage : rglm_pkg

// ---- src/rglm_mdio_slave.sv ----
/*
 * Management frame slave: turns serial frames on the management
 * pins into register address, write and read strobes.
 * Assumes the management clock is far slower than clk.
 */
`timescale 1ns/1ps
module rglm_mdio_slave (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Pins
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  // Register side
  output logic [15:0]      reg_addr,
  output logic             wr_pulse,
  output logic [15:0]      wr_data,
  output logic             rd_pulse,
  input  wire logic [15:0] rd_data
);

  logic                      mdc_s1, mdc_s2, mdc_s3, dio_s1, dio_s2;
  logic                      rise;
  logic                      act_reg;
  logic [5:0]                pre_reg;
  logic [4:0]                idx_reg;
  logic [1:0]                op_reg;
  logic [15:0]               sh_reg, rsh_reg, full;
  rglm_pkg::rglm_mdio_state_t st_reg;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      {mdc_s1, mdc_s2, mdc_s3} <= 3'h0;
      {dio_s1, dio_s2} <= 2'h3;
    end else begin
      {mdc_s1, mdc_s2, mdc_s3} <= {mdc, mdc_s1, mdc_s2};
      {dio_s1, dio_s2} <= {mdio_in, dio_s1};
    end
  end

  assign rise = mdc_s2 & ~mdc_s3;
  assign full = {sh_reg[14:0], dio_s2};

  // ****************************************
  // Frame decode
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= rglm_pkg::MS_HUNT;
      pre_reg <= 6'h00;
      idx_reg <= 5'h00;
      op_reg <= 2'h0;
      act_reg <= 1'b0;
      sh_reg <= 16'h0000;
      reg_addr <= 16'h0000;
      wr_pulse <= 1'b0;
      wr_data <= 16'h0000;
      rd_pulse <= 1'b0;
    end else begin
      wr_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      if (rise) begin
        case (st_reg)
          rglm_pkg::MS_HUNT: begin
            sh_reg <= 16'h0000;
            idx_reg <= 5'h01;
            if (dio_s2) begin
              if (pre_reg != rglm_pkg::PRE_LEN) pre_reg <= pre_reg + 6'h01;
            end else if (pre_reg == rglm_pkg::PRE_LEN) begin
              st_reg <= rglm_pkg::MS_FRAME;
            end else begin
              pre_reg <= 6'h00;
            end
          end
          rglm_pkg::MS_FRAME: begin
            sh_reg <= full;
            idx_reg <= idx_reg + 5'h01;
            if (idx_reg == rglm_pkg::BIT_HDR) begin
              op_reg <= full[11:10];
              act_reg <= full[13:12] == rglm_pkg::ST_C45 &&
                         full[9:5] == rglm_pkg::PORT_ADDR &&
                         full[4:0] == rglm_pkg::DEV_ADDR;
              rd_pulse <= full[13:12] == rglm_pkg::ST_C45 &&
                          full[9:5] == rglm_pkg::PORT_ADDR &&
                          full[4:0] == rglm_pkg::DEV_ADDR &&
                          full[11];
            end
            if (idx_reg == rglm_pkg::BIT_LAST) begin
              st_reg <= rglm_pkg::MS_HUNT;
              pre_reg <= 6'h00;
              if (act_reg) begin
                case (op_reg)
                  rglm_pkg::OP_ADDR: reg_addr <= full;
                  rglm_pkg::OP_WR: begin
                    wr_pulse <= 1'b1;
                    wr_data <= full;
                  end
                  rglm_pkg::OP_RDINC: reg_addr <= reg_addr + 16'h0001;
                  default: ;
                endcase
              end
            end
          end
          default: st_reg <= rglm_pkg::MS_HUNT;
        endcase
      end
    end
  end

  // ****************************************
  // Read data drive
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      mdio_oe <= 1'b0;
      mdio_out <= 1'b1;
      rsh_reg <= 16'h0000;
    end else if (rise && st_reg == rglm_pkg::MS_FRAME) begin
      if (idx_reg == rglm_pkg::BIT_TA && act_reg && op_reg[1]) begin
        mdio_oe <= 1'b1;
        mdio_out <= 1'b0;
      end else if (idx_reg == rglm_pkg::BIT_TA2 && mdio_oe) begin
        mdio_out <= rd_data[15];
        rsh_reg <= {rd_data[14:0], 1'b0};
      end else if (idx_reg == rglm_pkg::BIT_LAST) begin
        mdio_oe <= 1'b0;
        mdio_out <= 1'b1;
      end else if (mdio_oe) begin
        mdio_out <= rsh_reg[15];
        rsh_reg <= {rsh_reg[14:0], 1'b0};
      end
    end
  end

endmodule : rglm_mdio_slave

// ---- src/rglm_regs.sv ----
/*
 * Receiver amplifier gain, local oscillator power and RF output
 * detector register bank behind the management pins.
 * Assumes gain_mode, det_kind, the power inputs, det_sample and
 * pm_tick come from logic on clk; mdc and mdio come from pins.
 */
`timescale 1ns/1ps

// Summary of operation
// - Gain voltage registers accept writes only in manual gain mode.
// - Each channel group holds four words: XI, XQ, YI, YQ.
// - Output target registers apply only in automatic gain mode.
// - Features register reports the output detector kind.
// - Read-only local oscillator power monitor, signed hundredths dBm.
// - Read-write local oscillator power set-point, signed hundredths dBm.
// - Read-only lowest permitted set-point, signed hundredths dBm.
// - Read-only highest permitted set-point, signed hundredths dBm.
// - Live detector reading per channel, read-only unsigned word.
// - Per-channel detector average over each monitoring interval.
// - Per-channel detector minimum and maximum over each interval.
module rglm_regs (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Management pins
  input  wire logic             mdc,
  input  wire logic             mdio_in,
  output logic                  mdio_out,
  output logic                  mdio_oe,
  // Receiver control and features
  input  wire logic [1:0]       gain_mode,
  input  wire logic [1:0]       det_kind,
  // Local oscillator power
  input  wire logic [15:0]      lo_power_meas,
  input  wire logic [15:0]      lo_power_min,
  input  wire logic [15:0]      lo_power_max,
  output logic [15:0]           lo_power_set,
  // Amplifier drive
  output logic [3:0][15:0]      gain_volt,
  output logic                  gain_volt_valid,
  output logic [3:0][15:0]      out_target,
  output logic                  out_target_valid,
  // Detector samples
  input  wire logic             det_sample,
  input  wire logic [3:0][15:0] det_value,
  input  wire logic             pm_tick
);

  logic [15:0] addr, wr_d, rd_d_reg, rd_mux, lo_set_reg;
  logic        wr_p, rd_p, acc_en, div_busy, avg_done;
  logic        gv_valid_reg, tg_valid_reg, ge;
  logic [15:0] gain_reg [rglm_pkg::NCH];
  logic [15:0] target_reg [rglm_pkg::NCH];
  logic [15:0] tgt_out_reg [rglm_pkg::NCH];
  logic [15:0] live_reg [rglm_pkg::NCH];
  logic [15:0] avg_reg [rglm_pkg::NCH];
  logic [15:0] min_reg [rglm_pkg::NCH];
  logic [15:0] max_reg [rglm_pkg::NCH];
  logic [15:0] rmin_reg [rglm_pkg::NCH];
  logic [15:0] rmax_reg [rglm_pkg::NCH];
  logic [39:0] sum_reg [rglm_pkg::NCH];
  logic [39:0] snap_reg [rglm_pkg::NCH];
  logic [39:0] num_reg;
  logic [23:0] cnt_reg, den_reg, rem_reg, rem_nx;
  logic [24:0] rem_sh;
  logic [15:0] q_reg, q_nx;
  logic [5:0]  step_reg;
  logic [1:0]  ch_reg;

  // ****************************************
  // Management frame slave
  // ****************************************
  rglm_mdio_slave u_mdio (
    .clk      (clk),
    .rst      (rst),
    .mdc      (mdc),
    .mdio_in  (mdio_in),
    .mdio_out (mdio_out),
    .mdio_oe  (mdio_oe),
    .reg_addr (addr),
    .wr_pulse (wr_p),
    .wr_data  (wr_d),
    .rd_pulse (rd_p),
    .rd_data  (rd_d_reg)
  );

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    rd_mux = rglm_pkg::RST_VAL;
    case (addr[15:2])
      rglm_pkg::A_FEAT[15:2]: begin
        if (addr[1:0] == 2'h0) rd_mux = {rglm_pkg::FEAT_PAD, det_kind};
      end
      rglm_pkg::A_GAIN[15:2]:    rd_mux = gain_reg[addr[1:0]];
      rglm_pkg::A_TARGET[15:2]:  rd_mux = target_reg[addr[1:0]];
      rglm_pkg::A_LO_MON[15:2]: begin
        case (addr[1:0])
          2'h0:    rd_mux = lo_power_meas;
          2'h1:    rd_mux = lo_set_reg;
          2'h2:    rd_mux = lo_power_min;
          default: rd_mux = lo_power_max;
        endcase
      end
      rglm_pkg::A_DET_CUR[15:2]: rd_mux = live_reg[addr[1:0]];
      rglm_pkg::A_DET_AVG[15:2]: rd_mux = avg_reg[addr[1:0]];
      rglm_pkg::A_DET_MIN[15:2]: rd_mux = min_reg[addr[1:0]];
      rglm_pkg::A_DET_MAX[15:2]: rd_mux = max_reg[addr[1:0]];
      default:                   rd_mux = rglm_pkg::RST_VAL;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) rd_d_reg <= rglm_pkg::RST_VAL;
    else if (rd_p) rd_d_reg <= rd_mux;
  end

  // ****************************************
  // Local oscillator set-point
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      lo_set_reg <= rglm_pkg::RST_VAL;
    end else if (wr_p && addr == rglm_pkg::A_LO_SET) begin
      if ($signed(wr_d) < $signed(lo_power_min))
        lo_set_reg <= lo_power_min;
      else if ($signed(wr_d) > $signed(lo_power_max))
        lo_set_reg <= lo_power_max;
      else
        lo_set_reg <= wr_d;
    end
  end

  assign lo_power_set = lo_set_reg;

  // ****************************************
  // Mode qualifiers and sample count
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      gv_valid_reg <= 1'b0;
      tg_valid_reg <= 1'b0;
    end else begin
      gv_valid_reg <= gain_mode == rglm_pkg::GM_MANUAL;
      tg_valid_reg <= gain_mode == rglm_pkg::GM_AUTO;
    end
  end

  assign gain_volt_valid = gv_valid_reg;
  assign out_target_valid = tg_valid_reg;
  assign acc_en = det_sample && cnt_reg != rglm_pkg::CNT_MAX;

  always_ff @(posedge clk) begin
    if (rst) cnt_reg <= 24'h000000;
    else if (pm_tick) cnt_reg <= {23'h000000, det_sample};
    else if (acc_en) cnt_reg <= cnt_reg + 24'h000001;
  end

  // ****************************************
  // Per-channel registers
  // ****************************************
  for (genvar g = 0; g < rglm_pkg::NCH; g++) begin : g_ch
    always_ff @(posedge clk) begin
      if (rst) begin
        gain_reg[g] <= rglm_pkg::RST_VAL;
      end else if (wr_p && addr[15:2] == rglm_pkg::A_GAIN[15:2] &&
                   addr[1:0] == 2'(g) &&
                   gain_mode == rglm_pkg::GM_MANUAL) begin
        gain_reg[g] <= wr_d;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        target_reg[g] <= rglm_pkg::RST_VAL;
      end else if (wr_p && addr[15:2] == rglm_pkg::A_TARGET[15:2] &&
                   addr[1:0] == 2'(g)) begin
        target_reg[g] <= wr_d;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) tgt_out_reg[g] <= rglm_pkg::RST_VAL;
      else if (gain_mode == rglm_pkg::GM_AUTO)
        tgt_out_reg[g] <= target_reg[g];
    end

    assign gain_volt[g] = gain_reg[g];
    assign out_target[g] = tgt_out_reg[g];

    always_ff @(posedge clk) begin
      if (rst) live_reg[g] <= rglm_pkg::RST_VAL;
      else if (det_sample) live_reg[g] <= det_value[g];
    end

    always_ff @(posedge clk) begin
      if (rst) sum_reg[g] <= 40'h0000000000;
      else if (pm_tick)
        sum_reg[g] <= det_sample ? {rglm_pkg::SUM_PAD, det_value[g]}
                                 : 40'h0000000000;
      else if (acc_en)
        sum_reg[g] <= sum_reg[g] + {rglm_pkg::SUM_PAD, det_value[g]};
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        rmin_reg[g] <= rglm_pkg::RMIN_RST;
        rmax_reg[g] <= rglm_pkg::RST_VAL;
        min_reg[g] <= rglm_pkg::RST_VAL;
        max_reg[g] <= rglm_pkg::RST_VAL;
      end else begin
        if (pm_tick && cnt_reg != 24'h000000) begin
          min_reg[g] <= rmin_reg[g];
          max_reg[g] <= rmax_reg[g];
        end
        if (det_sample && (pm_tick || cnt_reg == 24'h000000)) begin
          rmin_reg[g] <= det_value[g];
          rmax_reg[g] <= det_value[g];
        end else if (det_sample) begin
          if (det_value[g] < rmin_reg[g]) rmin_reg[g] <= det_value[g];
          if (det_value[g] > rmax_reg[g]) rmax_reg[g] <= det_value[g];
        end
      end
    end
  end

  // ****************************************
  // Interval average divider
  // ****************************************
  assign rem_sh = {rem_reg, num_reg[39]};
  assign ge = rem_sh >= {1'b0, den_reg};
  assign rem_nx = ge ? 24'(rem_sh - {1'b0, den_reg}) : rem_sh[23:0];
  assign q_nx = {q_reg[14:0], ge};

  always_ff @(posedge clk) begin
    if (rst) begin
      div_busy <= 1'b0;
      avg_done <= 1'b0;
      ch_reg <= 2'h0;
      step_reg <= 6'h00;
      rem_reg <= 24'h000000;
      den_reg <= 24'h000001;
      q_reg <= 16'h0000;
      num_reg <= 40'h0000000000;
      for (int i = 0; i < rglm_pkg::NCH; i++) begin
        avg_reg[i] <= rglm_pkg::RST_VAL;
        snap_reg[i] <= 40'h0000000000;
      end
    end else begin
      avg_done <= 1'b0;
      if (pm_tick && cnt_reg != 24'h000000) begin
        div_busy <= 1'b1;
        ch_reg <= 2'h0;
        step_reg <= 6'h00;
        rem_reg <= 24'h000000;
        q_reg <= 16'h0000;
        den_reg <= cnt_reg;
        num_reg <= sum_reg[0];
        for (int i = 0; i < rglm_pkg::NCH; i++) snap_reg[i] <= sum_reg[i];
      end else if (div_busy) begin
        rem_reg <= rem_nx;
        q_reg <= q_nx;
        num_reg <= {num_reg[38:0], 1'b0};
        step_reg <= step_reg + 6'h01;
        if (step_reg == rglm_pkg::DIV_LAST) begin
          avg_reg[ch_reg] <= q_nx;
          step_reg <= 6'h00;
          rem_reg <= 24'h000000;
          q_reg <= 16'h0000;
          if (ch_reg == 2'(rglm_pkg::NCH - 1)) begin
            div_busy <= 1'b0;
            avg_done <= 1'b1;
          end else begin
            ch_reg <= ch_reg + 2'h1;
            num_reg <= snap_reg[2'(ch_reg + 2'h1)];
          end
        end
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_gain_manual;
    wr_p && addr == rglm_pkg::A_GAIN && gain_mode == rglm_pkg::GM_MANUAL
    |=> gain_volt[0] == $past(wr_d);
  endproperty
  a_gain_manual: assert property (p_gain_manual)
    else $error("gain write in manual mode not stored");

  property p_gain_ignore;
    wr_p && addr[15:2] == rglm_pkg::A_GAIN[15:2] &&
    gain_mode != rglm_pkg::GM_MANUAL |=> gain_volt == $past(gain_volt);
  endproperty
  a_gain_ignore: assert property (p_gain_ignore)
    else $error("gain write outside manual mode changed value");

  property p_order;
    rd_p && addr == rglm_pkg::A_GAIN + 16'h0003
    |=> rd_d_reg == $past(gain_volt[3]);
  endproperty
  a_order: assert property (p_order)
    else $error("fourth gain word is not y quadrature");

  property p_target;
    gain_mode != rglm_pkg::GM_AUTO
    |=> !out_target_valid && out_target == $past(out_target);
  endproperty
  a_target: assert property (p_target)
    else $error("output target applied outside automatic mode");

  property p_feat;
    rd_p && addr == rglm_pkg::A_FEAT |=> rd_d_reg[1:0] == $past(det_kind);
  endproperty
  a_feat: assert property (p_feat)
    else $error("features read does not give detector kind");

  property p_lo_mon;
    rd_p && addr == rglm_pkg::A_LO_MON
    |=> rd_d_reg == $past(lo_power_meas);
  endproperty
  a_lo_mon: assert property (p_lo_mon)
    else $error("power monitor read mismatch");

  property p_lo_set;
    wr_p && addr == rglm_pkg::A_LO_SET &&
    $signed(wr_d) >= $signed(lo_power_min) &&
    $signed(wr_d) <= $signed(lo_power_max)
    |=> lo_power_set == $past(wr_d);
  endproperty
  a_lo_set: assert property (p_lo_set)
    else $error("set-point write not stored");

  property p_lo_min;
    wr_p && addr == rglm_pkg::A_LO_SET &&
    $signed(wr_d) < $signed(lo_power_min)
    |=> lo_power_set == $past(lo_power_min);
  endproperty
  a_lo_min: assert property (p_lo_min)
    else $error("set-point below lowest limit");

  property p_lo_max;
    wr_p && addr == rglm_pkg::A_LO_SET &&
    $signed(wr_d) > $signed(lo_power_max) &&
    $signed(lo_power_min) <= $signed(lo_power_max)
    |=> lo_power_set == $past(lo_power_max);
  endproperty
  a_lo_max: assert property (p_lo_max)
    else $error("set-point above highest limit");

  property p_live;
    det_sample |=> live_reg[2] == $past(det_value[2]);
  endproperty
  a_live: assert property (p_live)
    else $error("live detector reading not captured");

  sequence s_close;
    pm_tick && cnt_reg != 24'h000000;
  endsequence

  sequence s_quiet;
    (!pm_tick) [*8];
  endsequence

  property p_avg;
    s_close ##1 s_quiet |-> ##[1:160] avg_done;
  endproperty
  a_avg: assert property (p_avg)
    else $error("interval average not published in time");

  property p_minmax;
    s_close |=> min_reg[0] <= max_reg[0] &&
                max_reg[1] == $past(rmax_reg[1]);
  endproperty
  a_minmax: assert property (p_minmax)
    else $error("interval minimum or maximum wrong");

endmodule : rglm_regs

// ---- dv/rglm_host.sv ----
/*
 * Host model: management frames on mdc and the shared data line.
 * Assumes the device samples on mdc rise and turns the line at TA.
 */
`timescale 1ns/1ps
module rglm_host (
  // Clock
  input  wire logic clk,
  // Management pins
  output logic      mdc,
  output logic      mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  logic h_oe;
  logic h_dat;

  // Pull-up when nobody drives the line
  assign mdio_in = mdio_oe ? mdio_out : (h_oe ? h_dat : 1'b1);

  initial begin
    mdc = 1'b0;
    h_oe = 1'b0;
    h_dat = 1'b1;
  end

  // ****************************************
  // One frame: preamble, header, data
  // ****************************************
  task automatic frame(input logic [1:0] op, input logic [15:0] d,
                       output logic [15:0] q);
    logic [63:0] b;
    b = {32'hFFFFFFFF, rglm_pkg::ST_C45, op, rglm_pkg::PORT_ADDR,
         rglm_pkg::DEV_ADDR, 2'h2, d};
    q = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      h_oe <= !op[1] || i < 46;
      h_dat <= b[63 - i];
      repeat (8) @(posedge clk);
      if (i >= 48) q[63 - i] = mdio_in;
      mdc <= 1'b1;
      repeat (8) @(posedge clk);
      mdc <= 1'b0;
    end
    h_oe <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : frame
endmodule : rglm_host

// ---- dv/testbench.sv ----
/*
 * Self-checking bench for the bank, against an integer model.
 * Assumes rglm_regs and the rglm_host frame model.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  err_total++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module testbench;
  logic             clk, rst, mdc, mdio_in, mdio_out, mdio_oe;
  logic             det_sample, pm_tick, gv_ok, ot_ok;
  logic [1:0]       gain_mode, det_kind;
  logic [15:0]      lo_meas, lo_min, lo_max, lo_set, tv;
  logic [3:0][15:0] gain_volt, out_target, det_value;
  logic [15:0]      rq [$];
  int               err_total, checks_done, cnt, t;
  int               gm [4], sm [4], mn [4], mx [4], lv [4];

  rglm_regs rglm_regs_i (.clk(clk), .rst(rst), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .gain_mode(gain_mode), .det_kind(det_kind), .lo_power_meas(lo_meas),
    .lo_power_min(lo_min), .lo_power_max(lo_max), .lo_power_set(lo_set),
    .gain_volt(gain_volt), .gain_volt_valid(gv_ok),
    .out_target(out_target), .out_target_valid(ot_ok),
    .det_sample(det_sample), .det_value(det_value), .pm_tick(pm_tick));
  rglm_host rglm_host_i (.clk(clk), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe));

  // ****************************************
  // Bus tasks and verdict
  // ****************************************
  task automatic rd_seq(input logic [15:0] a, input int n);
    logic [15:0] q;
    rq.delete();
    rglm_host_i.frame(rglm_pkg::OP_ADDR, a, q);
    for (int k = 0; k < n; k++) begin
      rglm_host_i.frame(rglm_pkg::OP_RDINC, 16'h0000, q);
      rq.push_back(q);
    end
  endtask : rd_seq

  task automatic wr_rd(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] q;
    rq.delete();
    rglm_host_i.frame(rglm_pkg::OP_ADDR, a, q);
    rglm_host_i.frame(rglm_pkg::OP_WR, d, q);
    rglm_host_i.frame(rglm_pkg::OP_RD, 16'h0000, q);
    rq.push_back(q);
  endtask : wr_rd

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    complete_run();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(68460));
    rst = 1'b1;
    det_sample = 1'b0;
    pm_tick = 1'b0;
    gain_mode = rglm_pkg::GM_MANUAL;
    det_kind = 2'h0;
    lo_meas = 16'h0000;
    lo_min = 16'hFE0C;
    lo_max = 16'h012C;
    det_value = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    lo_meas <= 16'($urandom);
    det_kind <= 2'($urandom);
    repeat (4) @(posedge clk);
    rd_seq(rglm_pkg::A_FEAT, 1);
    `CHK("feat", {rglm_pkg::FEAT_PAD, det_kind}, rq[0])
    rd_seq(rglm_pkg::A_LO_MON, 4);
    `CHK("lo_mon", lo_meas, rq[0])
    `CHK("lo_set", rglm_pkg::RST_VAL, rq[1])
    `CHK("lo_min", lo_min, rq[2])
    `CHK("lo_max", lo_max, rq[3])
    rd_seq(rglm_pkg::A_RSVD, 10);
    for (int k = 0; k < 10; k++) `CHK("rsv_gain_tgt", 16'h0000, rq[k])
    for (int c = 0; c < 4; c++) begin
      gm[c] = $urandom_range(65535);
      wr_rd(rglm_pkg::A_GAIN + 16'(c), 16'(gm[c]));
      `CHK("gain", 16'(gm[c]), gain_volt[c])
    end
    `CHK("gain_valid", 1'b1, gv_ok)
    gain_mode <= rglm_pkg::GM_AUTO;
    wr_rd(rglm_pkg::A_GAIN, 16'(~gm[0]));
    `CHK("gain_valid_auto", 1'b0, gv_ok)
    `CHK("gain_locked", 16'(gm[0]), rq[0])
    rd_seq(rglm_pkg::A_GAIN, 4);
    for (int c = 0; c < 4; c++) `CHK("gain_rd", 16'(gm[c]), rq[c])
    for (int c = 0; c < 4; c++) begin
      tv = 16'($urandom);
      wr_rd(rglm_pkg::A_TARGET + 16'(c), tv);
      `CHK("target", tv, out_target[c])
    end
    `CHK("target_valid", 1'b1, ot_ok)
    gain_mode <= 2'h2;
    wr_rd(rglm_pkg::A_TARGET + 16'h0003, ~tv);
    `CHK("target_rw", ~tv, rq[0])
    `CHK("target_hold", tv, out_target[3])
    `CHK("target_valid_oth", 1'b0, ot_ok)
    `CHK("gain_valid_oth", 1'b0, gv_ok)
    gain_mode <= rglm_pkg::GM_MANUAL;
    wr_rd(rglm_pkg::A_LO_SET, 16'h0064);
    `CHK("set_rd", 16'h0064, rq[0])
    `CHK("set_port", 16'h0064, lo_set)
    `CHK("target_valid_man", 1'b0, ot_ok)
    wr_rd(rglm_pkg::A_LO_SET, 16'h0400);
    `CHK("set_hi", lo_max, rq[0])
    wr_rd(rglm_pkg::A_LO_SET, 16'h8000);
    `CHK("set_lo", lo_min, rq[0])
    wr_rd(rglm_pkg::A_LO_MON, 16'h5A5A);
    `CHK("mon_ro", lo_meas, rq[0])
    for (int c = 0; c < 4; c++) begin
      sm[c] = 0;
      mn[c] = 65535;
      mx[c] = 0;
    end
    cnt = 0;
    repeat (5) begin
      for (int c = 0; c < 4; c++) begin
        t = $urandom_range(65535);
        det_value[c] <= 16'(t);
        lv[c] = t;
        sm[c] += t;
        if (t < mn[c]) mn[c] = t;
        if (t > mx[c]) mx[c] = t;
      end
      det_sample <= 1'b1;
      cnt++;
      @(posedge clk);
      det_sample <= 1'b0;
      @(posedge clk);
    end
    rd_seq(rglm_pkg::A_DET_CUR, 4);
    for (int c = 0; c < 4; c++) `CHK("det_live", 16'(lv[c]), rq[c])
    pm_tick <= 1'b1;
    @(posedge clk);
    pm_tick <= 1'b0;
    repeat (170) @(posedge clk);
    rd_seq(rglm_pkg::A_DET_AVG, 12);
    for (int c = 0; c < 4; c++) begin
      `CHK("det_avg", 16'(sm[c] / cnt), rq[c])
      `CHK("det_min", 16'(mn[c]), rq[c + 4])
      `CHK("det_max", 16'(mx[c]), rq[c + 8])
    end
    complete_run();
  end
endmodule : testbench
